// ===== design/dual_synth_pkg.sv
// constants, word layout and target codes for the dual synthesizer config block
// assumes word position 1 is the first bit shifted in and 22 the last
package dual_synth_pkg;

    // ****************************************************
    // word layout (positions count from 1, first shifted)
    // ****************************************************
    localparam int WORD_LEN          = 22;
    localparam int POS_TGT_HI        = 1;
    localparam int POS_TGT_LO        = 2;
    localparam int POS_REF_FIRST     = 3;
    localparam int REF_LEN           = 15;
    localparam int POS_PHASE_SENSE   = 18;
    localparam int POS_PUMP_CURRENT  = 19;
    localparam int POS_TRISTATE      = 20;
    localparam int POS_LOCK_SELECT   = 21;
    localparam int POS_FREQ_OUT      = 22;
    localparam int POS_SWALLOW_FIRST = 3;
    localparam int SWALLOW_LEN       = 6;
    localparam int POS_MAIN_FIRST    = 10;
    localparam int MAIN_LEN          = 11;
    localparam int POS_MODULUS       = 21;
    localparam int POS_POWER_DOWN    = 22;

    // ****************************************************
    // feedback ratio
    // ****************************************************
    localparam int FB_LEN            = 18;
    localparam int PRESCALE_SHIFT_LO = 5;    // modulus 32
    localparam int PRESCALE_SHIFT_HI = 6;    // modulus 64

    // ****************************************************
    // target codes {target_select_hi, target_select_lo}
    // ****************************************************
    localparam logic [1:0] TGT_REF_SECOND = 2'h0;
    localparam logic [1:0] TGT_REF_FIRST  = 2'h1;
    localparam logic [1:0] TGT_CNT_SECOND = 2'h2;
    localparam logic [1:0] TGT_CNT_FIRST  = 2'h3;

    localparam int LOOP_FIRST  = 0;
    localparam int LOOP_SECOND = 1;
    localparam int LOOPS       = 2;

    // ****************************************************
    // asynchronous input bundle indices
    // ****************************************************
    localparam int IN_LOCK_FIRST = 0;
    localparam int IN_FB_FIRST   = 2;
    localparam int IN_REFCLK     = 4;
    localparam int IN_STROBE     = 5;
    localparam int ASYNC_W       = 6;

endpackage : dual_synth_pkg

// ===== design/serial_shifter.sv
// serial input shift register, clocked by the host's data clock
// assumes data is stable around each rising edge of serial_clock
`timescale 1ns/1ps
module serial_shifter
    import dual_synth_pkg::*;
(
    // link side
    input  wire logic                serial_clock,
    input  wire logic                arst_n,
    input  wire logic                serial_data,
    // parallel word
    output logic [WORD_LEN-1:0]      shift_word
);

    // ****************************************************
    // shift
    // ****************************************************
    // only edges shift; a clock parked high does nothing more
    always_ff @(posedge serial_clock or negedge arst_n)
    begin
        if (!arst_n)
            shift_word <= '0;
        else
            shift_word <= {shift_word[WORD_LEN-2:0], serial_data};
    end

    property p_shift;
        @(posedge serial_clock) disable iff (!arst_n)
        1'b1 |=> (shift_word[0] == $past(serial_data))
                 && (shift_word[WORD_LEN-1:1] == $past(shift_word[WORD_LEN-2:0]));
    endproperty
    a_shift: assert property (p_shift) else $error("serial shift lost a bit");

endmodule : serial_shifter

// ===== design/edge_divider.sv
// programmable divider counting synchronised input edges
// assumes edge_in is a one-cycle pulse on clk and ratio is at least 3
`timescale 1ns/1ps
module edge_divider #(
    parameter int WIDTH = 15
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // control
    input  wire logic             enable,
    input  wire logic             edge_in,
    input  wire logic [WIDTH-1:0] ratio,
    // output
    output logic                  tick
);

    logic [WIDTH-1:0] count;
    logic             last;

    assign last = (count + WIDTH'(1)) >= ratio;

    // ****************************************************
    // counter
    // ****************************************************
    // disabled counter is held cleared so it restarts in phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            count <= '0;
        else if (!enable)
            count <= '0;
        else if (edge_in)
            count <= last ? '0 : count + WIDTH'(1);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tick <= 1'b0;
        else
            tick <= enable && edge_in && last;
    end

endmodule : edge_divider

// ===== design/dual_synth_serial_config.sv
// serial programming front end and configuration latches of a dual synthesizer
// assumes the host stops serial_clock before raising load_strobe
`timescale 1ns/1ps
module dual_synth_serial_config
    import dual_synth_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          arst_n,
    // serial programming pins
    input  wire logic                          serial_clock,
    input  wire logic                          serial_data,
    input  wire logic                          load_strobe,
    // analog side indications
    input  wire logic                          reference_clock_pin,
    input  wire logic [LOOPS-1:0]              feedback_pin,
    input  wire logic [LOOPS-1:0]              lock_raw,
    // per loop reference settings
    output logic [LOOPS-1:0][REF_LEN-1:0]      ref_ratio,
    output logic [LOOPS-1:0]                   phase_sense,
    output logic [LOOPS-1:0]                   pump_high,
    output logic [LOOPS-1:0]                   pump_hiz,
    // per loop counter settings
    output logic [LOOPS-1:0][SWALLOW_LEN-1:0]  swallow_ratio,
    output logic [LOOPS-1:0][MAIN_LEN-1:0]     main_ratio,
    output logic [LOOPS-1:0]                   modulus_64,
    output logic [LOOPS-1:0]                   power_down,
    output logic [LOOPS-1:0][FB_LEN-1:0]       feedback_ratio,
    output logic [LOOPS-1:0]                   main_enable,
    output logic [LOOPS-1:0]                   comparator_enable,
    // shared
    output logic                               ref_counter_enable,
    output logic                               osc_hiz,
    output logic                               monitor_select,
    output logic                               monitor_pin
);

    // ****************************************************
    // decoding helpers
    // ****************************************************
    function automatic logic word_bit(input logic [WORD_LEN-1:0] w, input int pos);
        word_bit = w[WORD_LEN-pos];
    endfunction : word_bit

    // first bit of a field is its least significant
    function automatic logic [REF_LEN-1:0] word_field(input logic [WORD_LEN-1:0] w,
                                                      input int first, input int len);
        word_field = '0;
        for (int i = 0; i < REF_LEN; i++)
        begin
            if (i < len)
                word_field[i] = w[WORD_LEN-first-i];
        end
    endfunction : word_field

    function automatic logic [1:0] ref_code(input int loop);
        ref_code = (loop == LOOP_FIRST) ? TGT_REF_FIRST : TGT_REF_SECOND;
    endfunction : ref_code

    function automatic logic [1:0] cnt_code(input int loop);
        cnt_code = (loop == LOOP_FIRST) ? TGT_CNT_FIRST : TGT_CNT_SECOND;
    endfunction : cnt_code

    // ****************************************************
    // synchronisers
    // ****************************************************
    logic [ASYNC_W-1:0]  async_in;
    logic [ASYNC_W-1:0]  async_meta;
    logic [ASYNC_W-1:0]  async_sync;
    logic [ASYNC_W-1:0]  async_prev;
    logic [WORD_LEN-1:0] shift_word;
    logic [1:0]          target;
    logic                strobe_rise;
    logic [LOOPS-1:0]    lock_sync;
    logic [LOOPS-1:0]    fb_edge;
    logic                ref_edge;
    logic [LOOPS-1:0]    ref_tick;
    logic [LOOPS-1:0]    main_tick;
    logic [LOOPS-1:0]    lock_select;
    logic [LOOPS-1:0]    freq_out;
    logic                next_monitor;

    assign async_in = {load_strobe, reference_clock_pin, feedback_pin, lock_raw};

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            async_meta <= '0;
            async_sync <= '0;
            async_prev <= '0;
        end
        else
        begin
            async_meta <= async_in;
            async_sync <= async_meta;
            async_prev <= async_sync;
        end
    end

    assign strobe_rise = async_sync[IN_STROBE] && !async_prev[IN_STROBE];
    assign ref_edge    = async_sync[IN_REFCLK] && !async_prev[IN_REFCLK];
    assign lock_sync   = async_sync[IN_LOCK_FIRST +: LOOPS];
    assign fb_edge     = async_sync[IN_FB_FIRST +: LOOPS] & ~async_prev[IN_FB_FIRST +: LOOPS];

    // ****************************************************
    // serial link
    // ****************************************************
    serial_shifter u_shifter
    (
        .serial_clock (serial_clock),
        .arst_n       (arst_n),
        .serial_data  (serial_data),
        .shift_word   (shift_word)
    );

    // word is quiet while the strobe rises, so sampling it two
    // synchroniser stages later is safe; costs the 50 ns setup margin
    assign target = {word_bit(shift_word, POS_TGT_HI), word_bit(shift_word, POS_TGT_LO)};

    // ****************************************************
    // per loop latches
    // ****************************************************
    genvar gl;
    generate
        for (gl = 0; gl < LOOPS; gl++)
        begin : g_loop
            // reference set; loads regardless of power state
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    ref_ratio[gl]   <= '0;
                    phase_sense[gl] <= 1'b0;
                    pump_high[gl]   <= 1'b0;
                    lock_select[gl] <= 1'b0;
                    freq_out[gl]    <= 1'b0;
                end
                else if (strobe_rise && target == ref_code(gl))
                begin
                    ref_ratio[gl]   <= word_field(shift_word, POS_REF_FIRST, REF_LEN);
                    phase_sense[gl] <= word_bit(shift_word, POS_PHASE_SENSE);
                    pump_high[gl]   <= word_bit(shift_word, POS_PUMP_CURRENT);
                    lock_select[gl] <= word_bit(shift_word, POS_LOCK_SELECT);
                    freq_out[gl]    <= word_bit(shift_word, POS_FREQ_OUT);
                end
            end

            logic tristate;
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    tristate <= 1'b0;
                else if (strobe_rise && target == ref_code(gl))
                    tristate <= word_bit(shift_word, POS_TRISTATE);
            end

            // counter set; swallow takes six bits, position 9 dropped
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    swallow_ratio[gl] <= '0;
                    main_ratio[gl]    <= '0;
                    modulus_64[gl]    <= 1'b0;
                    power_down[gl]    <= 1'b0;
                end
                else if (strobe_rise && target == cnt_code(gl))
                begin
                    swallow_ratio[gl] <= SWALLOW_LEN'(word_field(shift_word, POS_SWALLOW_FIRST,
                                                                 SWALLOW_LEN));
                    main_ratio[gl]    <= MAIN_LEN'(word_field(shift_word, POS_MAIN_FIRST, MAIN_LEN));
                    modulus_64[gl]    <= word_bit(shift_word, POS_MODULUS);
                    power_down[gl]    <= word_bit(shift_word, POS_POWER_DOWN);
                end
            end

            // total division; no check of main against swallow, host's duty
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    feedback_ratio[gl] <= '0;
                else
                    feedback_ratio[gl] <= (FB_LEN'(main_ratio[gl])
                                           << (modulus_64[gl] ? PRESCALE_SHIFT_HI : PRESCALE_SHIFT_LO))
                                          + FB_LEN'(swallow_ratio[gl]);
            end

            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    pump_hiz[gl]          <= 1'b0;
                    main_enable[gl]       <= 1'b0;
                    comparator_enable[gl] <= 1'b0;
                end
                else
                begin
                    pump_hiz[gl]          <= tristate || power_down[gl];
                    main_enable[gl]       <= !power_down[gl];
                    comparator_enable[gl] <= !power_down[gl];
                end
            end

            edge_divider #(.WIDTH(REF_LEN)) u_ref_div
            (
                .clk     (mclk),
                .arst_n  (arst_n),
                .enable  (ref_counter_enable),
                .edge_in (ref_edge),
                .ratio   (ref_ratio[gl]),
                .tick    (ref_tick[gl])
            );

            edge_divider #(.WIDTH(FB_LEN)) u_main_div
            (
                .clk     (mclk),
                .arst_n  (arst_n),
                .enable  (main_enable[gl]),
                .edge_in (fb_edge[gl]),
                .ratio   (feedback_ratio[gl]),
                .tick    (main_tick[gl])
            );

            sequence s_strobe_edge;
                $rose(async_sync[IN_STROBE]);
            endsequence

            sequence s_counter_load;
                s_strobe_edge ##0 (target == cnt_code(gl));
            endsequence

            sequence s_ref_load;
                s_strobe_edge ##0 (target == ref_code(gl));
            endsequence

            property p_ref_load;
                @(posedge mclk) disable iff (!arst_n)
                s_ref_load |=> ref_ratio[gl] == word_field($past(shift_word), POS_REF_FIRST, REF_LEN)
                               && phase_sense[gl] == word_bit($past(shift_word), POS_PHASE_SENSE);
            endproperty
            a_ref_load: assert property (p_ref_load) else $error("reference set not loaded");

            property p_other_kept;
                @(posedge mclk) disable iff (!arst_n)
                s_ref_load |=> $stable(main_ratio[gl]) && $stable(power_down[gl]);
            endproperty
            a_other_kept: assert property (p_other_kept) else $error("counter set disturbed");

            property p_swallow;
                @(posedge mclk) disable iff (!arst_n)
                s_counter_load |=> swallow_ratio[gl] ==
                    SWALLOW_LEN'(word_field($past(shift_word), POS_SWALLOW_FIRST, SWALLOW_LEN));
            endproperty
            a_swallow: assert property (p_swallow) else $error("swallow count wrong");

            property p_feedback;
                @(posedge mclk) disable iff (!arst_n)
                s_counter_load |=> ##1 feedback_ratio[gl] ==
                    FB_LEN'(main_ratio[gl]) * (modulus_64[gl] ? FB_LEN'(64) : FB_LEN'(32))
                    + FB_LEN'(swallow_ratio[gl]);
            endproperty
            a_feedback: assert property (p_feedback) else $error("feedback ratio wrong");

            property p_pump;
                @(posedge mclk) disable iff (!arst_n)
                s_ref_load |=> pump_high[gl] == word_bit($past(shift_word), POS_PUMP_CURRENT);
            endproperty
            a_pump: assert property (p_pump) else $error("pump current not loaded");

            property p_power_down;
                @(posedge mclk) disable iff (!arst_n)
                power_down[gl] |=> pump_hiz[gl] && !main_enable[gl] && !comparator_enable[gl];
            endproperty
            a_power_down: assert property (p_power_down) else $error("loop not shut down");
        end
    endgenerate

    // ****************************************************
    // shared controls
    // ****************************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_counter_enable <= 1'b0;
            osc_hiz            <= 1'b0;
        end
        else
        begin
            ref_counter_enable <= !(&power_down);
            osc_hiz            <= &power_down;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            monitor_select <= 1'b0;
        else if (strobe_rise && target == TGT_REF_FIRST)
            monitor_select <= 1'(LOOP_FIRST);
        else if (strobe_rise && target == TGT_REF_SECOND)
            monitor_select <= 1'(LOOP_SECOND);
    end

    // ****************************************************
    // monitor multiplexer
    // ****************************************************
    // counter-reset test codes just hold the pin low
    always_comb
    begin
        next_monitor = 1'b0;
        unique case ({freq_out[LOOP_FIRST], freq_out[LOOP_SECOND]})
            2'h0:
            begin
                unique case ({lock_select[LOOP_FIRST], lock_select[LOOP_SECOND]})
                    2'h0: next_monitor = 1'b0;
                    2'h1: next_monitor = lock_sync[LOOP_SECOND];
                    2'h2: next_monitor = lock_sync[LOOP_FIRST];
                    2'h3: next_monitor = lock_sync[LOOP_FIRST] && lock_sync[LOOP_SECOND];
                endcase
            end
            2'h1: next_monitor = lock_select[LOOP_SECOND] ? main_tick[LOOP_SECOND] : ref_tick[LOOP_SECOND];
            2'h2: next_monitor = lock_select[LOOP_FIRST] ? main_tick[LOOP_FIRST] : ref_tick[LOOP_FIRST];
            2'h3: next_monitor = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            monitor_pin <= 1'b0;
        else
            monitor_pin <= next_monitor;
    end

    property p_osc;
        @(posedge mclk) disable iff (!arst_n)
        arst_n |=> (osc_hiz == ($past(power_down) == 2'h3)) && (ref_counter_enable != osc_hiz);
    endproperty
    a_osc: assert property (p_osc) else $error("reference shutdown wrong");

    property p_lock;
        @(posedge mclk) disable iff (!arst_n)
        (freq_out == 2'h0) && (lock_select == 2'h3)
            |=> monitor_pin == $past(lock_sync[LOOP_FIRST] && lock_sync[LOOP_SECOND]);
    endproperty
    a_lock: assert property (p_lock) else $error("lock monitor wrong");

endmodule : dual_synth_serial_config

// ===== tb/serial_host.sv
// host model driving the three-wire programming pins
// assumes the block samples the word only after the strobe rises
`timescale 1ns/1ps
module serial_host
(
    // programming pins
    output logic serial_clock,
    output logic serial_data,
    output logic load_strobe
);
    initial
    begin
        serial_clock = 1'b0;
        serial_data  = 1'b0;
        load_strobe  = 1'b0;
    end

    // ****************************************
    // one word: 32 ns link clock, then strobe
    // ****************************************
    task automatic send_word(input logic [21:0] w, input bit park);
        #3;
        if (serial_clock)
        begin
            #16 serial_clock = 1'b0;
        end
        for (int i = 21; i >= 0; i--)
        begin
            serial_data = w[i];
            #16 serial_clock = 1'b1;
            #16 serial_clock = park && i == 0;
        end
        // released line, not the last bit
        serial_data = ~w[0];
        #60 load_strobe = 1'b1;
        #80 load_strobe = 1'b0;
        #60;
    endtask : send_word
endmodule : serial_host

// ===== tb/testbench.sv
// self-checking bench for the serial configuration block
// assumes the host model owns the link pins; feedback inputs idle, reference clock toggled only in the test-route check
`timescale 1ns/1ps
module testbench import dual_synth_pkg::*;;
    typedef struct {logic [1:0] t; logic [14:0] a; logic [10:0] b; logic [4:0] f; bit park;} row_s;
    logic                              mclk, arst_n, sclk, sdata, strobe, ref_en, osc_hiz, mon_sel, mon_pin;
    logic [LOOPS-1:0]                  lock_raw, phase_sense, pump_high, pump_hiz, modulus_64, main_enable, comp_en;
    logic [LOOPS-1:0]                  power_down, m_ps = '0, m_ph = '0, m_ts = '0, m_mod = '0, m_pd = '0;
    logic [LOOPS-1:0][REF_LEN-1:0]     ref_ratio, m_ref = '0;
    logic [LOOPS-1:0][SWALLOW_LEN-1:0] swallow_ratio, m_sw = '0;
    logic [LOOPS-1:0][MAIN_LEN-1:0]    main_ratio, m_mn = '0;
    logic [LOOPS-1:0][FB_LEN-1:0]      fb;
    logic                              m_sel = 1'b0;
    logic                              refclk;
    int                                error_cnt = 0, total_checks = 0;
    // ref rows: f = phase, pump, tristate, lock select, freq out; counter rows: f[1:0] = modulus, power-down
    row_s rows [7] = '{'{2'h1, 15'h7fff, 11'h000, 5'h12, 1'b0}, '{2'h0, 15'h0003, 11'h000, 5'h08, 1'b0},
                       '{2'h3, 15'h007f, 11'h7ff, 5'h02, 1'b1}, '{2'h2, 15'h0000, 11'h003, 5'h01, 1'b0},
                       '{2'h3, 15'h0005, 11'h064, 5'h01, 1'b1}, '{2'h0, 15'h1234, 11'h000, 5'h0e, 1'b0},
                       '{2'h2, 15'h003f, 11'h040, 5'h00, 1'b0}};

    dual_synth_serial_config uut (.mclk(mclk), .arst_n(arst_n), .serial_clock(sclk), .serial_data(sdata),
        .load_strobe(strobe), .reference_clock_pin(refclk), .feedback_pin(2'b00), .lock_raw(lock_raw),
        .ref_ratio(ref_ratio), .phase_sense(phase_sense), .pump_high(pump_high), .pump_hiz(pump_hiz),
        .swallow_ratio(swallow_ratio), .main_ratio(main_ratio), .modulus_64(modulus_64), .power_down(power_down),
        .feedback_ratio(fb), .main_enable(main_enable), .comparator_enable(comp_en), .ref_counter_enable(ref_en),
        .osc_hiz(osc_hiz), .monitor_select(mon_sel), .monitor_pin(mon_pin));
    serial_host host (.serial_clock(sclk), .serial_data(sdata), .load_strobe(strobe));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    // position p of the word sits at w[22-p]
    function automatic logic [21:0] mk(input row_s r);
        logic [21:0] w;
        w = {r.t, 20'h0};
        for (int k = 0; k < 20; k++)
            w[19-k] = (k > 17 || (!r.t[1] && k > 14)) ? r.f[19-k] : (r.t[1] && k > 6) ? r.b[k-7] : r.a[k];
        return w;
    endfunction : mk

    task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic check_all();
        logic [LOOPS-1:0][FB_LEN-1:0] e_fb;
        for (int l = 0; l < LOOPS; l++)
            e_fb[l] = m_mn[l] * (m_mod[l] ? 18'h40 : 18'h20) + m_sw[l];
        chk("ref_ratio", 36'(m_ref), 36'(ref_ratio));
        chk("phase_sense", 36'(m_ps), 36'(phase_sense));
        chk("pump_high", 36'(m_ph), 36'(pump_high));
        chk("pump_hiz", 36'(m_ts | m_pd), 36'(pump_hiz));
        chk("swallow_ratio", 36'(m_sw), 36'(swallow_ratio));
        chk("main_ratio", 36'(m_mn), 36'(main_ratio));
        chk("modulus_64", 36'(m_mod), 36'(modulus_64));
        chk("power_down", 36'(m_pd), 36'(power_down));
        chk("feedback_ratio", 36'(e_fb), 36'(fb));
        chk("main_enable", 36'(m_pd ^ 2'h3), 36'(main_enable));
        chk("comparator_enable", 36'(m_pd ^ 2'h3), 36'(comp_en));
        chk("osc_hiz", 36'(&m_pd), 36'(osc_hiz));
        chk("ref_counter_enable", 36'(~&m_pd), 36'(ref_en));
        chk("monitor_select", 36'(m_sel), 36'(mon_sel));
    endtask : check_all

    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        row_s r;
        int   l;
        int   n;
        arst_n   <= 1'b0;
        lock_raw <= 2'b00;
        refclk   <= 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check_all();
        foreach (rows[i])
        begin
            r = rows[i];
            host.send_word(mk(r), r.park);
            l = r.t[0] ? LOOP_FIRST : LOOP_SECOND;
            if (!r.t[1])
            begin
                m_ref[l] = r.a;
                m_ps[l]  = r.f[4];
                m_ph[l]  = r.f[3];
                m_ts[l]  = r.f[2];
                m_sel    = (l == LOOP_SECOND);
            end
            else
            begin
                m_sw[l]  = r.a[5:0];
                m_mn[l]  = r.b;
                m_mod[l] = r.f[1];
                m_pd[l]  = r.f[0];
            end
            check_all();
        end
        // both loops pick lock, so the pin shows their and
        for (int v = 0; v < 4; v++)
        begin
            @(posedge mclk) lock_raw <= 2'(v);
            repeat (5) @(posedge mclk);
            @(negedge mclk);
            chk("monitor_pin", 36'(v == 3), 36'(mon_pin));
        end
        // test route: first loop reference divider, ratio 3, 13 reference edges give 4 ticks
        r = '{2'h1, 15'h0003, 11'h000, 5'h01, 1'b0};
        host.send_word(mk(r), r.park);
        n = 0;
        for (int e = 0; e < 104; e++)
        begin
            @(posedge mclk) refclk <= e[2];
            @(negedge mclk) n += int'(mon_pin);
        end
        chk("monitor_ticks", 36'h4, 36'(n));
        // reset in mid-run clears every latch
        @(posedge mclk) arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("reset_main_enable", 36'h0, 36'(main_enable));
        {m_ps, m_ph, m_ts, m_mod, m_pd, m_ref, m_sw, m_mn, m_sel} = '0;
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check_all();
        give_verdict();
    end

    // hang guard: eight words and the tests after them take about 8.5 us, well under the 50 us limit
    initial
    begin
        #50000;
        error_cnt++;
        give_verdict();
    end
endmodule : testbench
